// ### design/panel_io_pkg.sv
// Shared constants for the operator panel I/O image link.
package panel_io_pkg;

    // Image sizes in bits.
    localparam int IN_IMAGE_BITS = 128;
    localparam int OUT_IMAGE_BITS = 64;
    localparam int GEN_IN_BITS = 32;
    localparam int KEY_BITS = 64;
    localparam int GEN_OUT_BITS = 8;

    // Key rows, as byte offsets in the input image; LED rows sit at bytes 0 to 7 of the output image.
    localparam logic [3:0] KEY_LED_ROW_0 = 4'h4;
    localparam logic [3:0] KEY_LED_ROW_1 = 4'h5;
    localparam logic [3:0] KEY_LED_ROW_2 = 4'h6;
    localparam logic [3:0] KEY_LED_ROW_3 = 4'h7;
    localparam logic [3:0] KEY_LED_ROW_4 = 4'h8;
    localparam logic [3:0] KEY_LED_ROW_5 = 4'h9;
    localparam logic [3:0] KEY_LED_ROW_6 = 4'ha;
    localparam logic [3:0] KEY_LED_ROW_7 = 4'hb;
    // Bits 3 and 7 of the last three rows carry no key.
    localparam logic [63:0] KEY_LED_MASK = 64'h777777ffffffffff;

    // Pulse generator counters.
    localparam int PGEN_UNITS = 3;
    localparam int PGEN_BITS = 8;
    localparam logic [127:0] PGEN_HIDE_MASK = 128'hff000000ffffffffffffffffffffffff;

    // Sub panel fields.
    localparam int OVR1_BITS = 5;
    localparam int OVR2_BITS = 3;
    localparam int SUB_BITS = 13;
    // Inputs shared with the pendant connector, from bit 13 through bit 21.
    localparam int SHARED_FIRST = 13;
    localparam int SHARED_BITS = 9;
    // Input byte with the selectable common.
    localparam int SEL_FIRST = 24;
    // Highest input bit with a fixed common.
    localparam logic [4:0] FIXED_LAST = 5'h17;

    // General output pins, as bit positions in the output image.
    localparam int PEND_DO_BIT = 43;
    localparam int DO_POS [GEN_OUT_BITS] = '{43, 47, 51, 55, 59, 60, 61, 62};

    // Controller register offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ESTOP = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_IN_0 = 8'h10;
    localparam logic [7:0] REG_IN_1 = 8'h14;
    localparam logic [7:0] REG_IN_2 = 8'h18;
    localparam logic [7:0] REG_IN_3 = 8'h1c;
    localparam logic [7:0] REG_OUT_0 = 8'h20;
    localparam logic [7:0] REG_OUT_1 = 8'h24;

    // Control bits and reset values.
    localparam int CTRL_BITS = 4;
    localparam int CTRL_ALARM = 0;
    localparam int CTRL_PEND_DI = 1;
    localparam int CTRL_PEND_DO = 2;
    localparam int CTRL_PGEN_NEAR = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [4:0] ESTOP_RESET = 5'h00;
    localparam int IRQ_BITS = 2;
    localparam int IRQ_CHANGE = 0;
    localparam int IRQ_ESTOP = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

endpackage

// ### design/panel_link_if.sv
// Signals between the operator panel and its link controller.
interface panel_link_if;
    logic [panel_io_pkg::IN_IMAGE_BITS-1:0] in_image;
    logic [panel_io_pkg::OUT_IMAGE_BITS-1:0] out_image;
    logic out_load;
    logic system_alarm;
    logic power_ok;
    logic pendant_di_sel;
    logic pendant_do_sel;

    modport panel
    (
        output in_image,
        input out_image,
        input out_load,
        input system_alarm,
        input power_ok,
        input pendant_di_sel,
        input pendant_do_sel
    );

    modport controller
    (
        input in_image,
        output out_image,
        output out_load,
        output system_alarm,
        output power_ok,
        output pendant_di_sel,
        output pendant_do_sel
    );
endinterface

// ### design/panel_io_device.sv
// Operator panel end: builds the input image and drives the panel outputs.
// Notes on behaviour
// RULE1 - Fixed-common input bytes read open pins as 0.
// RULE2 - Fourth byte open pins follow its common.
// RULE3 - Common at +24V gives negative logic.
// RULE4 - Controller maps emergency stop into fixed bytes.
// RULE5 - Alarm or power loss turns outputs off.
// RULE6 - Only nearest slave pulse generators used, three.
// RULE7 - Pendant selection replaces shared general inputs.
// RULE8 - Routed pendant output disables general copy.
// RULE9 - Keys in rows, LEDs same bit positions.
// RULE10 - Sub panel supplies override codes, protect key.
// RULE11 - Power switches never enter the link image.
// RULE12 - Pulse counters fixed at input bytes 12-14.
// RULE13 - First override Gray code with parity bit.
// RULE14 - Outputs zero from reset until written.
//
// The plain strobed port was decided locally.
module panel_io_device
(
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Link to the controller.
    panel_link_if.panel link,
    // General input pins, high while the contact is closed.
    input wire logic [panel_io_pkg::GEN_IN_BITS-1:0] general_closed,
    input wire logic selectable_input_common_high,
    // Sub panel.
    input wire logic subpanel_fitted,
    input wire logic [panel_io_pkg::OVR1_BITS-1:0] first_override_pos,
    input wire logic [panel_io_pkg::OVR2_BITS-1:0] second_override_pos,
    input wire logic memory_protect_key,
    // Pendant connector.
    input wire logic [panel_io_pkg::SHARED_BITS-1:0] pendant_closed,
    input wire logic [panel_io_pkg::PGEN_UNITS-1:0] pgen_pulse,
    input wire logic [panel_io_pkg::PGEN_UNITS-1:0] pgen_dir,
    output logic pendant_out,
    // Keys and LEDs.
    input wire logic [panel_io_pkg::KEY_BITS-1:0] key_pressed,
    output logic [panel_io_pkg::KEY_BITS-1:0] led_drive,
    // General output pins.
    output logic [panel_io_pkg::GEN_OUT_BITS-1:0] general_out,
    // Power switches and supply.
    input wire logic power_on_switch,
    input wire logic power_off_switch,
    input wire logic panel_power_ok,
    output logic cabinet_power_on,
    output logic cabinet_power_off
);
    import panel_io_pkg::*;

    logic [IN_IMAGE_BITS-1:0] in_image_q;
    logic [OUT_IMAGE_BITS-1:0] out_q;
    logic [KEY_BITS-1:0] led_q;
    logic [GEN_OUT_BITS-1:0] gen_out_q;
    logic pendant_q;
    logic cab_on_q;
    logic cab_off_q;
    logic [PGEN_BITS-1:0] pgen_cnt_q [PGEN_UNITS];

    // RULE1 - fixed common inputs.
    wire logic [GEN_IN_BITS-1:0] fixed_bits = general_closed;

    // RULE2 - selectable common byte.
    // RULE3 - negative logic sense.
    wire logic [7:0] sel_byte = general_closed[GEN_IN_BITS-1:SEL_FIRST]
        ^ {8{selectable_input_common_high}};

    // RULE13 - Gray code, parity.
    wire logic [OVR1_BITS-1:0] ovr1_gray = first_override_pos ^ (first_override_pos >> 1);
    wire logic ovr1_parity = ^ovr1_gray;
    wire logic [OVR2_BITS-1:0] ovr2_gray = second_override_pos ^ (second_override_pos >> 1);
    wire logic ovr2_parity = ^ovr2_gray;

    // RULE10 - sub panel fields.
    wire logic [SUB_BITS-1:0] sub_bits =
        {memory_protect_key, 1'b0, ovr2_parity, 1'b0, ovr2_gray, ovr1_parity, ovr1_gray};
    wire logic [SUB_BITS-1:0] low_bits = subpanel_fitted ? sub_bits : fixed_bits[SUB_BITS-1:0];

    // RULE7 - pendant shared inputs.
    wire logic [SHARED_BITS-1:0] shared_bits = link.pendant_di_sel ? pendant_closed
        : fixed_bits[SHARED_FIRST+SHARED_BITS-1:SHARED_FIRST];

    // RULE11 - switches kept off link.
    wire logic [GEN_IN_BITS-1:0] gen_image =
        {sel_byte, fixed_bits[SEL_FIRST-1:SHARED_FIRST+SHARED_BITS], shared_bits, low_bits};

    // RULE9 - key state rows.
    wire logic [KEY_BITS-1:0] key_image = key_pressed & KEY_LED_MASK;

    // RULE12 - fixed counter bytes.
    wire logic [IN_IMAGE_BITS-1:0] in_image_d =
        {8'h00, pgen_cnt_q[2], pgen_cnt_q[1], pgen_cnt_q[0], key_image, gen_image};

    // RULE5 - outputs off on alarm.
    wire logic shutdown = link.system_alarm | ~link.power_ok | ~panel_power_ok;

    // RULE14 - hold until written.
    wire logic [OUT_IMAGE_BITS-1:0] out_d = shutdown ? '0
        : (link.out_load ? link.out_image : out_q);

    // RULE9 - LED same positions.
    wire logic [KEY_BITS-1:0] led_d = out_d & KEY_LED_MASK;

    wire logic [GEN_OUT_BITS-1:0] do_bits;

    genvar gi;
    generate
        for (gi = 0; gi < GEN_OUT_BITS; gi++)
        begin : g_do
            if (DO_POS[gi] == PEND_DO_BIT)
            begin : g_shared
                // RULE8 - routed output disabled.
                assign do_bits[gi] = out_d[DO_POS[gi]] & ~link.pendant_do_sel;
            end
            else
            begin : g_plain
                assign do_bits[gi] = out_d[DO_POS[gi]];
            end
        end
    endgenerate

    // RULE8 - pendant output routing.
    wire logic pendant_d = out_d[PEND_DO_BIT] & link.pendant_do_sel;

    // RULE6 - three counter units.
    generate
        for (gi = 0; gi < PGEN_UNITS; gi++)
        begin : g_pgen
            wire logic [PGEN_BITS-1:0] step_up = pgen_cnt_q[gi] + PGEN_BITS'(1);
            wire logic [PGEN_BITS-1:0] step_dn = pgen_cnt_q[gi] - PGEN_BITS'(1);

            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pgen_cnt_q[gi] <= '0;
                end
                else if (clk_en && pgen_pulse[gi])
                begin
                    pgen_cnt_q[gi] <= pgen_dir[gi] ? step_dn : step_up;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_image_q <= '0;
        end
        else if (clk_en)
        begin
            in_image_q <= in_image_d;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= '0;
            led_q <= '0;
            gen_out_q <= '0;
            pendant_q <= 1'b0;
        end
        else if (clk_en)
        begin
            out_q <= out_d;
            led_q <= led_d;
            gen_out_q <= do_bits;
            pendant_q <= pendant_d;
        end
    end

    // Power switch signals go straight to the cabinet wiring, one flop deep.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cab_on_q <= 1'b0;
            cab_off_q <= 1'b0;
        end
        else if (clk_en)
        begin
            cab_on_q <= power_on_switch;
            cab_off_q <= power_off_switch;
        end
    end

    assign link.in_image = in_image_q;
    assign led_drive = led_q;
    assign general_out = gen_out_q;
    assign pendant_out = pendant_q;
    assign cabinet_power_on = cab_on_q;
    assign cabinet_power_off = cab_off_q;

endmodule

// ### design/panel_io_host.sv
// Link controller end: register port, output image writer and input event interrupts.
module panel_io_host
(
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Link to the panel.
    panel_link_if.controller link,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Controller state.
    input wire logic cnc_alarm,
    input wire logic cnc_power_ok
);
    import panel_io_pkg::*;

    logic [CTRL_BITS-1:0] ctrl_q;
    logic [4:0] estop_sel_q;
    logic [IRQ_BITS-1:0] stat_q;
    logic [IRQ_BITS-1:0] mask_q;
    logic [OUT_IMAGE_BITS-1:0] out_q;
    logic load_q;
    logic alarm_q;
    logic pwr_q;
    logic [IN_IMAGE_BITS-1:0] in_prev_q;
    logic [31:0] rdata_q;
    logic irq_q;

    wire logic wr_ctrl = reg_write && reg_addr == REG_CTRL;
    wire logic wr_estop = reg_write && reg_addr == REG_ESTOP;
    wire logic wr_mask = reg_write && reg_addr == REG_IRQ_MASK;
    wire logic wr_out0 = reg_write && reg_addr == REG_OUT_0;
    wire logic wr_out1 = reg_write && reg_addr == REG_OUT_1;
    wire logic rd_stat = reg_read && reg_addr == REG_IRQ_STAT;

    // RULE4 - estop in fixed bytes.
    wire logic estop_ok = reg_wdata[31:5] == 27'h0000000 && reg_wdata[4:0] <= FIXED_LAST;

    // RULE6 - nearest slave counters.
    wire logic [IN_IMAGE_BITS-1:0] in_view = ctrl_q[CTRL_PGEN_NEAR] ? link.in_image
        : (link.in_image & PGEN_HIDE_MASK);

    wire logic ev_change = link.in_image != in_prev_q;
    // RULE4 - estop active low.
    wire logic ev_estop = in_prev_q[estop_sel_q] & ~link.in_image[estop_sel_q];
    wire logic [IRQ_BITS-1:0] events = {ev_estop, ev_change};
    wire logic [IRQ_BITS-1:0] stat_d = (stat_q & ~{IRQ_BITS{rd_stat}}) | events;

    wire logic [31:0] read_mux =
        reg_addr == REG_CTRL ? {28'h0000000, ctrl_q} :
        reg_addr == REG_ESTOP ? {27'h0000000, estop_sel_q} :
        reg_addr == REG_IRQ_STAT ? {30'h00000000, stat_q} :
        reg_addr == REG_IRQ_MASK ? {30'h00000000, mask_q} :
        reg_addr == REG_IN_0 ? in_view[31:0] :
        reg_addr == REG_IN_1 ? in_view[63:32] :
        reg_addr == REG_IN_2 ? in_view[95:64] :
        reg_addr == REG_IN_3 ? in_view[127:96] :
        reg_addr == REG_OUT_0 ? out_q[31:0] :
        reg_addr == REG_OUT_1 ? out_q[63:32] : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            estop_sel_q <= ESTOP_RESET;
            mask_q <= IRQ_RESET;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= reg_wdata[CTRL_BITS-1:0];
            end
            if (wr_estop && estop_ok)
            begin
                estop_sel_q <= reg_wdata[4:0];
            end
            if (wr_mask)
            begin
                mask_q <= reg_wdata[IRQ_BITS-1:0];
            end
        end
    end

    // RULE14 - image written by word.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= '0;
            load_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_out0)
            begin
                out_q[31:0] <= reg_wdata;
            end
            if (wr_out1)
            begin
                out_q[63:32] <= reg_wdata;
            end
            load_q <= wr_out0 | wr_out1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_q <= 1'b0;
            pwr_q <= 1'b0;
            stat_q <= IRQ_RESET;
            irq_q <= 1'b0;
            in_prev_q <= '0;
            rdata_q <= 32'h00000000;
        end
        else if (clk_en)
        begin
            // RULE5 - forward system alarm.
            alarm_q <= cnc_alarm | ctrl_q[CTRL_ALARM];
            pwr_q <= cnc_power_ok;
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
            in_prev_q <= link.in_image;
            rdata_q <= reg_read ? read_mux : 32'h00000000;
        end
    end

    assign link.out_image = out_q;
    assign link.out_load = load_q;
    assign link.system_alarm = alarm_q;
    assign link.power_ok = pwr_q;
    // RULE7 - pendant input select.
    assign link.pendant_di_sel = ctrl_q[CTRL_PEND_DI];
    // RULE8 - pendant output select.
    assign link.pendant_do_sel = ctrl_q[CTRL_PEND_DO];
    assign reg_rdata = rdata_q;
    assign irq = irq_q;

endmodule

// ### verification/panel_io_chk.sv
// Concurrent checks on the panel link signals and the panel output pins.
module panel_io_chk
(
    // Clock and reset.
    input logic ref_clk,
    input logic rst_n,
    // Link signals.
    input logic [127:0] in_image,
    input logic [63:0] out_image,
    input logic out_load,
    input logic system_alarm,
    input logic power_ok,
    input logic pendant_do_sel,
    // Panel pins.
    input logic panel_power_ok,
    input logic power_on_switch,
    input logic cabinet_power_on,
    input logic pendant_out,
    input logic [63:0] led_drive,
    input logic [7:0] general_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import panel_io_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire shut = system_alarm || !power_ok || !panel_power_ok;
    sequence s_load;
        out_load && !shut;
    endsequence
    sequence s_idle;
        !out_load && !shut;
    endsequence
    a_shutdown_clears_out: assert property (
        shut |=> led_drive == 64'h0 && general_out == 8'h0 && !pendant_out)
        else $error("outputs not cleared on shutdown");
    a_load_shows_leds: assert property (
        s_load |=> led_drive == ($past(out_image) & KEY_LED_MASK))
        else $error("led rows differ from loaded image");
    a_led_unused_dark: assert property (
        (led_drive & ~KEY_LED_MASK) == 64'h0)
        else $error("unused led bit driven");
    a_do_pendant_off: assert property (
        (s_load ##0 pendant_do_sel) |=> !general_out[0])
        else $error("routed output still on general pin");
    a_outputs_hold: assert property (
        s_idle ##0 $stable(pendant_do_sel) |=> $stable(led_drive) && $stable(general_out))
        else $error("outputs changed without a load");
    a_image_needs_load: assert property (
        !$stable(out_image) |-> out_load)
        else $error("output image changed without load pulse");
    a_reset_leds_dark: assert property (
        $rose(rst_n) ##0 (!out_load)[*3] |-> led_drive == 64'h0 && general_out == 8'h0)
        else $error("outputs on after reset without load");
    a_cabinet_copy: assert property (
        $past(rst_n) |-> cabinet_power_on == $past(power_on_switch))
        else $error("cabinet power on not a copy of the switch");
    a_top_byte_zero: assert property (
        in_image[127:120] == 8'h00)
        else $error("spare input byte not zero");
endmodule

// ### verification/operator_panel_io_image_tb_top.sv
// Self-checking bench joining the panel end and the link controller end.
module operator_panel_io_image_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import panel_io_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic cnc_alarm = 1'h0;
    logic cnc_power_ok = 1'h1;
    logic [31:0] general_closed = 32'h0;
    logic common_high = 1'h0;
    logic sub_fit = 1'h0;
    logic protect = 1'h0;
    logic pon = 1'h0;
    logic poff = 1'h0;
    logic ppok = 1'h1;
    logic [4:0] ovr1 = 5'h0;
    logic [2:0] ovr2 = 3'h0;
    logic [8:0] pend_in = 9'h0;
    logic [2:0] pg_pulse = 3'h0;
    logic [2:0] pg_dir = 3'h2;
    logic [63:0] keys = 64'h0;
    logic [31:0] reg_rdata;
    logic [63:0] led_drive;
    logic [7:0] general_out;
    logic irq, pendant_out, cab_on, cab_off;
    logic [31:0] rv;
    logic [3:0] ctrl = 4'h0;
    int err_total = 0;
    int compares = 0;
    int seed = 61;
    int unsigned out_w [2];
    panel_link_if link ();
    panel_io_device i_panel_io_device (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1),
        .link(link), .general_closed(general_closed), .selectable_input_common_high(common_high),
        .subpanel_fitted(sub_fit), .first_override_pos(ovr1), .second_override_pos(ovr2),
        .memory_protect_key(protect), .pendant_closed(pend_in), .pgen_pulse(pg_pulse),
        .pgen_dir(pg_dir), .pendant_out(pendant_out), .key_pressed(keys), .led_drive(led_drive),
        .general_out(general_out), .power_on_switch(pon), .power_off_switch(poff),
        .panel_power_ok(ppok), .cabinet_power_on(cab_on), .cabinet_power_off(cab_off));
    panel_io_host i_panel_io_host (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1),
        .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .cnc_alarm(cnc_alarm),
        .cnc_power_ok(cnc_power_ok));
    panel_io_chk i_panel_io_chk (.ref_clk(ref_clk), .rst_n(rst_n), .in_image(link.in_image),
        .out_image(link.out_image), .out_load(link.out_load), .system_alarm(link.system_alarm),
        .power_ok(link.power_ok), .pendant_do_sel(link.pendant_do_sel), .panel_power_ok(ppok),
        .power_on_switch(pon), .cabinet_power_on(cab_on), .pendant_out(pendant_out),
        .led_drive(led_drive), .general_out(general_out));
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        if (a == REG_CTRL)
            ctrl = d[3:0];
        @(posedge ref_clk);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge ref_clk);
        reg_read <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Model of the low input word from the pin levels.
    function automatic logic [31:0] exp_in0();
        int v;
        int g1;
        int g2;
        v = general_closed ^ (common_high ? 32'hff000000 : 32'h0);
        if (ctrl[1])
            v = (v & ~(32'h1ff << 13)) | (int'(pend_in) << 13);
        g1 = ovr1 ^ (ovr1 >> 1);
        g2 = ovr2 ^ (ovr2 >> 1);
        if (sub_fit)
            v = (v & ~32'h1fff) | g1 | ((^g1) << 5) | (g2 << 6) | ((^g2) << 10) | (protect << 12);
        return v;
    endfunction
    // Model of the panel pins after a load of the two output words.
    task automatic chk_out();
        logic [63:0] img;
        logic [7:0] go;
        img = {out_w[1], out_w[0]};
        for (int i = 0; i < 8; i++)
            go[i] = img[DO_POS[i]];
        if (ctrl[2])
            go[0] = 1'h0;
        chk("led", led_drive, img & KEY_LED_MASK);
        chk("dout", general_out, go);
        chk("pend", pendant_out, ctrl[2] & img[PEND_DO_BIT]);
    endtask
    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        results();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        rd(REG_CTRL, rv);
        chk("ctrl", rv, 64'h0);
        chk("led0", led_drive, 64'h0);
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            if (i == 4)
                wr(REG_CTRL, 32'h2);
            @(posedge ref_clk);
            general_closed <= $random(seed);
            keys <= {$random(seed), $random(seed)};
            pend_in <= $random(seed);
            common_high <= i[0];
            pon <= ~pon;
            poff <= i[1];
            settle(3);
            chk("in0", link.in_image[31:0], exp_in0());
            chk("cab", {cab_on, cab_off}, {pon, poff});
            chk("keys", link.in_image[95:32], keys & KEY_LED_MASK);
            rd(REG_IN_1, rv);
            chk("in1", rv, keys[31:0]);
        end
        $display("test inputs done");
        for (int p = 0; p < 21; p++)
        begin
            @(posedge ref_clk);
            sub_fit <= 1'h1;
            ovr1 <= p[4:0];
            ovr2 <= p[2:0];
            protect <= p[1];
            settle(3);
            chk("sub", link.in_image[31:0], exp_in0());
        end
        sub_fit <= 1'h0;
        $display("test sub panel done");
        wr(REG_CTRL, 32'h0);
        for (int m = 0; m < 5; m++)
        begin
            if (m == 4)
                wr(REG_CTRL, 32'h4);
            out_w[0] = $random(seed);
            out_w[1] = $random(seed) | 32'h800;
            wr(REG_OUT_0, out_w[0]);
            wr(REG_OUT_1, out_w[1]);
            settle(2);
            chk_out();
            @(posedge ref_clk);
            cnc_alarm <= (m == 0) || (m == 4);
            ppok <= (m != 1);
            cnc_power_ok <= (m != 2);
            if (m == 3)
                wr(REG_CTRL, 32'h1);
            settle(3);
            out_w = '{0, 0};
            chk_out();
            @(posedge ref_clk);
            cnc_alarm <= 1'h0;
            ppok <= 1'h1;
            cnc_power_ok <= 1'h1;
            if (m == 3)
                wr(REG_CTRL, 32'h0);
            settle(4);
            chk_out();
        end
        $display("test outputs done");
        wr(REG_IRQ_MASK, 32'h1);
        rd(REG_IRQ_STAT, rv);
        @(posedge ref_clk);
        general_closed <= general_closed ^ 32'h10;
        for (int k = 0; k < 8 && irq !== 1'h1; k++)
            @(posedge ref_clk);
        #1;
        chk("irq", irq, 64'h1);
        rd(REG_IRQ_STAT, rv);
        chk("stat", rv, 64'h1);
        settle(3);
        chk("irq", irq, 64'h0);
        wr(REG_IRQ_MASK, 32'h0);
        @(posedge ref_clk);
        general_closed <= general_closed ^ 32'h10;
        settle(5);
        chk("irqm", irq, 64'h0);
        wr(REG_ESTOP, 32'h2);
        wr(REG_ESTOP, 32'h18);
        rd(REG_ESTOP, rv);
        chk("estop", rv, 64'h2);
        @(posedge ref_clk);
        general_closed <= general_closed | 32'h4;
        settle(4);
        rd(REG_IRQ_STAT, rv);
        chk("stat", rv, 64'h1);
        @(posedge ref_clk);
        general_closed <= general_closed & ~32'h4;
        settle(4);
        rd(REG_IRQ_STAT, rv);
        chk("fall", rv, 64'h3);
        rd(8'hfc, rv);
        chk("unmapped", rv, 64'h0);
        $display("test interrupts done");
        for (int c = 0; c < 2; c++)
        begin
            for (int k = 0; k < 5; k++)
            begin
                @(posedge ref_clk);
                pg_pulse <= 3'h3;
                @(posedge ref_clk);
                pg_pulse <= 3'h0;
            end
            if (c == 0)
            begin
                settle(3);
                rd(REG_IN_3, rv);
                chk("pgen_off", rv, 64'h0);
                chk("pgen_raw", link.in_image[119:96], 64'h00fb05);
                wr(REG_CTRL, 32'h8);
            end
        end
        settle(3);
        chk("pgen", link.in_image[119:96], 64'h00f60a);
        rd(REG_IN_3, rv);
        chk("pgen_near", rv, 64'h00f60a);
        $display("test counters done");
        results();
    end
endmodule
